/* logic/erc_config.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - first source route bits 7:5, reset off
// - codes 1..6 pick ain0..3, positive_ref_zero, negative_ref_zero
// - second source route bits 4:2, reset off
// - second source uses same pin order
// - mode 0: ready on dedicated pin only
// - mode 1: ready also on shared pin, only while cs is high between frames
// - serial link is mode 1
// - launch on rising, sample on falling edge
module erc_config
    import erc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_din,
    output logic            spi_dout,
    input  wire logic       data_ready,
    input  wire logic       data_taken,
    output erc_route_t      first_excitation_source,
    output erc_route_t      second_excitation_source,
    output logic            dedicated_ready_pin_n,
    output logic            shared_ready_active,
    output erc_cfg_t        cfg_out
);
    // configuration register, system clock domain
    erc_cfg_t   cfg_reg;
    erc_cfg_t   cfg_next;
    logic       ready_reg;
    logic       ready_next;

    // link domain: clocked by sclk, cleared while cs is high
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    logic [6:0] data_sh_reg;
    logic [6:0] data_sh_next;
    logic [7:0] rd_sh_reg;
    logic [7:0] rd_sh_next;
    logic       dout_reg;
    logic       dout_next;

    // write hand-over: kept across the end of the frame
    logic [7:0] wdata_reg;
    logic [7:0] wdata_next;
    logic       wtog_reg;
    logic       wtog_next;

    // system clock side of the write hand-over
    logic [2:0] wtog_sync_reg;
    logic [2:0] wtog_sync_next;
    logic       wtog_seen_reg;
    logic       wtog_seen_next;
    logic       wtog_agree;
    logic       wr_pulse;

    // named decodes of the frame position
    logic       in_cmd_phase;
    logic       in_data_phase;
    logic       frame_full;
    logic       last_data_bit;
    logic       cmd_is_write;
    logic       cmd_is_read;
    logic       write_commit;
    logic       read_launch;

    // named decodes of the ready logic
    logic       ready_set;
    logic       ready_clr;

    // frame layout: eight command bits, then eight data bits, msb first;
    // falling edges are counted, so a count of 8 means the command is in
    // and a count of 16 means the frame is full; later edges are ignored
    // a frame that ends early never reaches the commit and writes nothing
    assign in_cmd_phase  = (bit_cnt_reg < ERC_CNT_CMD_DONE);
    assign in_data_phase = (bit_cnt_reg >= ERC_CNT_CMD_DONE) && (bit_cnt_reg < ERC_CNT_FRAME_DONE);
    assign frame_full    = (bit_cnt_reg == ERC_CNT_FRAME_DONE);
    assign last_data_bit = (bit_cnt_reg == (ERC_CNT_FRAME_DONE - 5'h01));

    // only the low two command bits are decoded; the rest are ignored
    // codes 00 and 11 do nothing, so an idle line of ones is harmless
    assign cmd_is_write  = (cmd_reg[1:0] == ERC_CMD_WRITE);
    assign cmd_is_read   = (cmd_reg[1:0] == ERC_CMD_READ);
    assign write_commit  = last_data_bit && cmd_is_write;
    assign read_launch   = (bit_cnt_reg == ERC_CNT_CMD_DONE) && cmd_is_read;

    // bit count stops at a full frame so extra edges change nothing
    // five bits reach the full-frame count of sixteen and hold there
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        if (!frame_full) begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
        end
    end

    // command byte shifts in first
    always_comb begin
        cmd_next = cmd_reg;
        if (in_cmd_phase) begin
            cmd_next = {cmd_reg[6:0], spi_din};
        end
    end

    // data byte shifts in next; its last bit joins it at the commit
    always_comb begin
        data_sh_next = data_sh_reg;
        if (in_data_phase) begin
            data_sh_next = {data_sh_reg[5:0], spi_din};
        end
    end

    // bit counter: samples on falling edges, cleared while cs is high
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_reg <= 5'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // command shifter, same edge and frame clear
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            cmd_reg <= 8'h00;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    // data shifter, same edge and frame clear
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            data_sh_reg <= 7'h00;
        end else begin
            data_sh_reg <= data_sh_next;
        end
    end

    // a finished write frame toggles wtog_reg and holds its byte
    always_comb begin
        wdata_next = wdata_reg;
        wtog_next  = wtog_reg;
        if (write_commit) begin
            wdata_next = {data_sh_reg, spi_din};
            wtog_next  = ~wtog_reg;
        end
    end

    // not cleared by cs high: the toggle must outlive the frame so that
    // the system clock still sees it; only the system reset clears it
    // sys_rst is taken asynchronously here; the link clock rests low while
    // the system is in reset, so its release cannot meet a sampling edge
    always_ff @(negedge spi_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            wtog_reg <= 1'b0;
        end else begin
            wtog_reg <= wtog_next;
        end
    end

    // write byte, same edge; read by the system clock only after the
    // toggle has crossed, by which time it no longer moves
    always_ff @(negedge spi_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            wdata_reg <= 8'h00;
        end else begin
            wdata_reg <= wdata_next;
        end
    end

    // read shifter loads the register at the first data rising edge;
    // cfg_reg only moves a few system clocks after a write frame ends,
    // so it is quasi-static during a read frame and needs no synchroniser
    // zeros shift in behind the byte; bits past the eighth read as zero
    always_comb begin
        dout_next  = rd_sh_reg[7];
        rd_sh_next = {rd_sh_reg[6:0], 1'b0};
        if (read_launch) begin
            dout_next  = cfg_reg[7];
            rd_sh_next = {cfg_reg[6:0], 1'b0};
        end
    end

    // output bit: launched on rising edges only, cleared while cs is high
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            dout_reg <= 1'b0;
        end else begin
            dout_reg <= dout_next;
        end
    end

    // read shift register, same edge and frame clear
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            rd_sh_reg <= 8'h00;
        end else begin
            rd_sh_reg <= rd_sh_next;
        end
    end

    // write toggle crosses through three flops; a change counts once the
    // second and third agree, which keeps a metastable stage out
    // toggling rather than pulsing lets the slow clock catch a short frame
    assign wtog_sync_next = {wtog_sync_reg[1:0], wtog_reg};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wtog_sync_reg <= 3'h0;
        end else begin
            wtog_sync_reg <= wtog_sync_next;
        end
    end

    // agreeing stages that differ from the level last taken mark a write
    assign wtog_agree     = (wtog_sync_reg[2] == wtog_sync_reg[1]);
    assign wr_pulse       = wtog_agree && (wtog_sync_reg[2] != wtog_seen_reg);
    assign wtog_seen_next = wtog_agree ? wtog_sync_reg[2] : wtog_seen_reg;

    // level of the toggle last taken as a write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wtog_seen_reg <= 1'b0;
        end else begin
            wtog_seen_reg <= wtog_seen_next;
        end
    end

    // register update; the reserved bit always reads back zero
    // the minimum spacing between write frames keeps wdata_reg still here
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_pulse) begin
            cfg_next          = erc_cfg_t'(wdata_reg);
            cfg_next.reserved = 1'b0;
        end
    end

    // configuration register, zero after reset
    // trade-off: a write lands three to five system clocks after the frame,
    // the cost of crossing by toggle instead of a faster handshake
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg <= erc_cfg_t'(ERC_RESET);
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // route decoding: one generate per destination pin; code 0 and the
    // unused code 7 match no pin, so both leave the source disconnected
    // one-hot per pin so the analog switches need no further decode
    genvar g;
    generate
        for (g = 0; g < ERC_NUM_PINS; g++) begin : g_route
            logic first_hit;
            logic second_hit;
            assign first_hit  = (cfg_reg.first_source_route == 3'(g + 1));
            assign second_hit = (cfg_reg.second_source_route == 3'(g + 1));
            assign first_excitation_source[g]  = first_hit;
            assign second_excitation_source[g] = second_hit;
        end
    endgenerate

    // ready flag: a result sets it, the host taking the data clears it;
    // a clear in the same cycle as a new result loses, so fresh data is
    // never hidden from the host
    // both strobes come from logic on this clock, so no synchroniser
    assign ready_set = data_ready;
    assign ready_clr = data_taken;
    always_comb begin
        ready_next = ready_reg;
        if (ready_set) begin
            ready_next = 1'b1;
        end else if (ready_clr) begin
            ready_next = 1'b0;
        end
    end

    // ready register, clear after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
        end
    end

    // dedicated pin always shows ready, active low
    assign dedicated_ready_pin_n = ~ready_reg;

    // shared pin shows ready only in mode 1 and only between frames,
    // since inside a frame it carries read data
    assign shared_ready_active = cfg_reg.ready_signal_mode & ready_reg & spi_cs_n;

    // shared pin level: read data in a frame, low when showing ready
    // limitation: a host that keeps cs low between frames never sees
    // ready here and must watch the dedicated pin instead
    assign spi_dout = spi_cs_n ? ~shared_ready_active : dout_reg;

    // whole register for the host side
    assign cfg_out = cfg_reg;
endmodule

/* logic/erc_pkg.sv */
package erc_pkg;
    // register layout of the excitation routing register
    localparam int           ERC_WIDTH          = 8;
    localparam logic [7:0]   ERC_RESET          = 8'h00;
    localparam int           ERC_FIRST_MSB      = 7;
    localparam int           ERC_FIRST_LSB      = 5;
    localparam int           ERC_SECOND_MSB     = 4;
    localparam int           ERC_SECOND_LSB     = 2;
    localparam int           ERC_MODE_BIT       = 1;
    localparam int           ERC_RSVD_BIT       = 0;
    // serial frame: command byte then data byte
    localparam logic [1:0]   ERC_CMD_WRITE      = 2'h1;
    localparam logic [1:0]   ERC_CMD_READ       = 2'h2;
    localparam int           ERC_FRAME_BITS     = 16;
    localparam int           ERC_CMD_BITS       = 8;
    localparam logic [4:0]   ERC_CNT_CMD_DONE   = 5'h08;
    localparam logic [4:0]   ERC_CNT_FRAME_DONE = 5'h10;
    localparam int           ERC_NUM_PINS       = 6;
    // one-hot pin order: ain0, analog_in_one, analog_in_two, ain3, positive_ref_zero, negative_ref_zero
    typedef struct packed {
        logic negative_ref_zero;
        logic positive_ref_zero;
        logic analog_in_three;
        logic analog_in_two;
        logic analog_in_one;
        logic analog_in_zero;
    } erc_route_t;
    typedef struct packed {
        logic [2:0] first_source_route;
        logic [2:0] second_source_route;
        logic       ready_signal_mode;
        logic       reserved;
    } erc_cfg_t;
endpackage

/* sim/erc_config_properties.sv */
`timescale 1ns/100ps
module erc_config_properties
    import erc_pkg::*;
(
    input wire logic clk, sys_rst, spi_sclk, spi_cs_n, spi_din, spi_dout, data_ready, data_taken,
    input erc_route_t first_excitation_source, second_excitation_source,
    input wire logic dedicated_ready_pin_n, shared_ready_active,
    input erc_cfg_t cfg_out
);
    // one domain only
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [2:0] r1 = cfg_out.first_source_route;
    wire [2:0] r2 = cfg_out.second_source_route;
    wire [5:0] s1 = first_excitation_source;
    wire [5:0] s2 = second_excitation_source;
    wire md = cfg_out.ready_signal_mode;
    property p_off1; r1 inside {0, 7} |-> s1 == 6'h00; endproperty
    a_off1: assert property (p_off1) else $error("src1 on");
    property p_map1; r1 inside {[1:6]} |-> s1 == 6'h01 << (r1 - 3'h1); endproperty
    a_map1: assert property (p_map1) else $error("src1 pin");
    property p_off2; r2 inside {0, 7} |-> s2 == 6'h00; endproperty
    a_off2: assert property (p_off2) else $error("src2 on");
    property p_map2; r2 inside {[1:6]} |-> s2 == 6'h01 << (r2 - 3'h1); endproperty
    a_map2: assert property (p_map2) else $error("src2 pin");
    property p_md0; !md |-> !shared_ready_active; endproperty
    a_md0: assert property (p_md0) else $error("shared in mode 0");
    // cs settled for a cycle, so the async frame reset cannot race
    property p_md1; md && !dedicated_ready_pin_n && spi_cs_n && $past(spi_cs_n) |-> shared_ready_active && !spi_dout;
    endproperty
    a_md1: assert property (p_md1) else $error("shared missing");
    property p_set; $rose(data_ready) |-> ##[1:2] !dedicated_ready_pin_n; endproperty
    a_set: assert property (p_set) else $error("ready late");
    property p_clr; data_taken && !data_ready |-> ##[1:2] dedicated_ready_pin_n; endproperty
    a_clr: assert property (p_clr) else $error("ready stuck");
endmodule
bind erc_config erc_config_properties u_erc_config_properties (.*);

/* sim/erc_host.sv */
`timescale 1ns/100ps
// host end; link clock rests low outside frames
module erc_host (output logic spi_sclk = 0, output logic spi_cs_n = 1, output logic spi_din = 0, input wire logic spi_dout);
    task automatic xfer(logic [15:0] tx, output logic [7:0] rx);
        spi_cs_n = 0;
        for (int i = 15; i >= 0; i--) begin
            #24 spi_sclk = 1;
            spi_din = tx[i];
            #24 spi_sclk = 0;
            if (i < 8) rx[i] = spi_dout;
        end
        #24 spi_cs_n = 1;
        spi_din = ~spi_din; // released line shows no stale bit
    endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/100ps
module tb;
    import erc_pkg::*;
    logic clk = 0, sys_rst = 0, data_ready = 0, data_taken = 0, spi_sclk, spi_cs_n, spi_din, spi_dout;
    logic dedicated_ready_pin_n, shared_ready_active;
    erc_route_t first_excitation_source, second_excitation_source;
    erc_cfg_t cfg_out;
    logic [7:0] rd;
    int n_mismatch = 0, compares = 0;
    erc_config u_erc_config (.*);
    erc_host u_erc_host (.*);
    initial forever #50 clk = ~clk;
    task chk(string nm, logic [19:0] exp, logic [19:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, got);
        end
    endtask
    // gap keeps writes eight cycles apart
    task acc(logic [1:0] cmd, logic [7:0] d);
        u_erc_host.xfer({6'h00, cmd, d}, rd);
        repeat (8) @(negedge clk);
    endtask
    task automatic ev(ref logic s);
        s = 1;
        @(negedge clk);
        s = 0;
        repeat (3) @(negedge clk);
    endtask
    function logic [5:0] pn(logic [2:0] c);
        return c inside {0, 7} ? 6'h00 : 6'h01 << (c - 3'h1);
    endfunction
    task give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000 n_mismatch++;
        give_verdict;
    end
    initial begin
        @(negedge clk);
        sys_rst = 1; // a real rising edge clears the link-side toggle
        repeat (5) @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        chk("reset", {ERC_RESET, 12'h0}, {cfg_out, first_excitation_source, second_excitation_source});
        chk("reset pin", 20'h1, {19'h0, dedicated_ready_pin_n});
        // reserved bit written high must read back low
        for (int c = 0; c < 8; c++) begin
            acc(ERC_CMD_WRITE, {c[2:0], ~c[2:0], 2'h3});
            acc(ERC_CMD_READ, 8'h00);
            chk("route", {c[2:0], ~c[2:0], 2'h2, pn(c[2:0]), pn(~c[2:0])},
                {rd, first_excitation_source, second_excitation_source});
        end
        $display("routing test done");
        for (int m = 0; m < 2; m++) begin
            acc(ERC_CMD_WRITE, {6'h00, m[0], 1'b0});
            ev(data_ready);
            chk("ready", {1'b0, m[0], !m[0]}, {dedicated_ready_pin_n, shared_ready_active, spi_dout});
            ev(data_taken);
            chk("clear", 20'h5, {dedicated_ready_pin_n, shared_ready_active, spi_dout});
        end
        // result and take in one cycle: the result wins
        data_taken = 1;
        data_ready = 1;
        @(negedge clk);
        data_taken = 0;
        data_ready = 0;
        @(negedge clk);
        chk("set wins", 20'h0, {19'h0, dedicated_ready_pin_n});
        $display("ready test done");
        give_verdict;
    end
endmodule
